// [hdl/pdsi_top.sv]
// Top: parallel digital set-point input decoding, latching and scaling
//
// What this block does
// - Selector picks 3/4-digit BCD or 12/16-bit binary; 9999 disables all.
// - Settings 4 and 14 give a binary torque command, not a set-point.
// - Only settings 2, 3, 12, 13 add the analog compensation input.
// - Settings 0 to 4 ignore input bits 12 to 15.
// - Binary reads the word as hex; BCD reads each nibble as a digit.
// - Read timing 0 (reset default) samples continuously, unfiltered.
// - Read timing 1 captures only while the read strobe is high.
// - Read timing 1 holds the last captured value while the strobe is low.
// - Read timing 10 samples continuously through a skew filter.
// - Read timing 1, strobe low since reset: word is zero, output is bias.
// - Bias sets frequency at zero input; separate BCD and binary bias.
// - Gain sets frequency at full scale; separate BCD and binary gain.
// - Gain defaults to 60 Hz (50 Hz regional); gain writes above 400 Hz are clamped to 400 Hz.
// - Gain 9999 uses the decoded value directly as the frequency.
// - In direct mode the matching bias has no effect and cannot be set.
// - Increment setting writes are refused while the drive runs.
// - Bulk parameter clear leaves the increment setting unchanged.
// - A BCD digit above 9 is rejected; the last valid value is kept.
//
// The implementer's own choices: the address map and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
module pdsi_top
  import pdsi_pkg::*;
#(
  parameter int WIDTH = 16,
  parameter bit REGIONAL = 1'b0,
  parameter int SETTLE = FILTER_CYCLES
)
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  // Parallel input lines and strobe
  input wire logic [WIDTH-1:0] parallel_input_bits_i,
  input wire logic read_strobe_i,
  // Analog compensation and drive status
  input wire logic [15:0] analog_comp_i,
  input wire logic drive_running_i,
  input wire logic param_clear_i,
  // Parameter write port
  input wire logic [3:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rdata_o,
  // Results
  output logic [15:0] setpoint_o,
  output logic setpoint_valid_o,
  output logic [15:0] torque_cmd_o,
  output logic torque_valid_o,
  output logic [1:0] input_unit_increment_o
);
  // Gain reset value follows the regional variant
  localparam logic [15:0] GAIN_RST = REGIONAL ? GAIN_DEFAULT_REGIONAL : GAIN_DEFAULT;

  logic [13:0] input_method_select;
  logic [3:0] read_timing_select;
  logic [15:0] bcd_bias_setting;
  logic [15:0] bcd_gain_setting;
  logic [15:0] binary_bias_setting;
  logic [15:0] binary_gain_setting;
  logic [1:0] input_unit_increment;
  logic [15:0] captured;
  logic [15:0] filtered;
  logic [15:0] masked;
  logic [15:0] decoded;
  logic [15:0] last_valid;
  logic [15:0] full_scale;
  logic is_bcd;
  logic is_wide;
  logic is_torque;
  logic enabled;
  logic comp_on;
  logic digits_ok;
  logic [15:0] bias_sel;
  logic [15:0] gain_sel;
  logic busy;
  logic [16:0] sum;
  pdsi_scale_if sc ();

  // Mode decode from the selector
  assign enabled = input_method_select != SEL_OFF;
  assign is_wide = input_method_select >= SEL_BCD4;
  assign is_torque = input_method_select == SEL_TRQ12 || input_method_select == SEL_TRQ16;
  assign is_bcd = input_method_select == SEL_BCD3 || input_method_select == SEL_BCD3_COMP ||
                  input_method_select == SEL_BCD4 || input_method_select == SEL_BCD4_COMP;
  assign comp_on = input_method_select == SEL_BCD3_COMP || input_method_select == SEL_BIN12_COMP ||
                   input_method_select == SEL_BCD4_COMP || input_method_select == SEL_BIN16_COMP;
  assign full_scale = is_bcd ? (is_wide ? FS_BCD4 : FS_BCD3) : (is_wide ? FS_BIN16 : FS_BIN12);
  assign bias_sel = is_bcd ? bcd_bias_setting : binary_bias_setting;
  assign gain_sel = is_bcd ? bcd_gain_setting : binary_gain_setting;

  // Parameter writes; gains 9999 lock the matching bias, increment locked while running
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_b_i)
    begin
      input_method_select <= SEL_OFF;
      read_timing_select <= RT_CONT;
      bcd_bias_setting <= BIAS_DEFAULT;
      bcd_gain_setting <= GAIN_RST;
      binary_bias_setting <= BIAS_DEFAULT;
      binary_gain_setting <= GAIN_RST;
    end
    else if (param_clear_i)
    begin
      input_method_select <= SEL_OFF;
      read_timing_select <= RT_CONT;
      bcd_bias_setting <= BIAS_DEFAULT;
      bcd_gain_setting <= GAIN_RST;
      binary_bias_setting <= BIAS_DEFAULT;
      binary_gain_setting <= GAIN_RST;
    end
    else if (wr_i)
    begin
      if (addr_i == A_METHOD)
      begin
        input_method_select <= wdata_i[13:0];
      end
      else if (addr_i == A_TIMING)
      begin
        read_timing_select <= wdata_i[3:0];
      end
      else if (addr_i == A_BCD_BIAS && bcd_gain_setting != GAIN_DIRECT)
      begin
        bcd_bias_setting <= (wdata_i > FREQ_LIMIT) ? FREQ_LIMIT : wdata_i;
      end
      else if (addr_i == A_BCD_GAIN)
      begin
        bcd_gain_setting <= (wdata_i > FREQ_LIMIT && wdata_i != GAIN_DIRECT) ? FREQ_LIMIT : wdata_i;
      end
      else if (addr_i == A_BIN_BIAS && binary_gain_setting != GAIN_DIRECT)
      begin
        binary_bias_setting <= (wdata_i > FREQ_LIMIT) ? FREQ_LIMIT : wdata_i;
      end
      else if (addr_i == A_BIN_GAIN)
      begin
        binary_gain_setting <= (wdata_i > FREQ_LIMIT && wdata_i != GAIN_DIRECT) ? FREQ_LIMIT : wdata_i;
      end
    end
  end

  // Increment setting: parameter clear never touches it, writes refused while running
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_b_i)
    begin
      input_unit_increment <= INCR_DEFAULT;
    end
    else if (wr_i && addr_i == A_INCR && !drive_running_i)
    begin
      input_unit_increment <= wdata_i[1:0];
    end
  end

  // Skew filter for read timing 10
  pdsi_input_filter #(.WIDTH(WIDTH), .SETTLE(SETTLE)) u_filter (
    .ref_clk_i(ref_clk_i),
    .rst_b_i(rst_b_i),
    .raw_i(parallel_input_bits_i),
    .settled_o(filtered)
  );

  // Word capture; reset to zero so strobe-low power-up gives bias
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_b_i)
    begin
      captured <= '0;
    end
    else if (read_timing_select == RT_FILTER)
    begin
      captured <= filtered;
    end
    else if (read_timing_select == RT_STROBE)
    begin
      if (read_strobe_i)
      begin
        captured <= parallel_input_bits_i;
      end
    end
    else
    begin
      captured <= parallel_input_bits_i;
    end
  end

  // Upper lines dropped in narrow modes, then decoded
  assign masked = is_wide ? captured : {4'h0, captured[11:0]};
  assign digits_ok = masked[3:0] <= 4'd9 && masked[7:4] <= 4'd9 &&
                     masked[11:8] <= 4'd9 && masked[15:12] <= 4'd9;
  assign decoded = is_bcd ? 16'(masked[3:0] + 16'd10 * masked[7:4] + 16'd100 * masked[11:8] +
                   16'd1000 * masked[15:12]) : masked;

  // Last valid decoded value survives a bad BCD digit
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_b_i)
    begin
      last_valid <= '0;
    end
    else if (!is_bcd || digits_ok)
    begin
      last_valid <= decoded;
    end
  end

  // Start a new scaling pass whenever the scaler is idle in a scaled frequency mode
  assign sc.value = last_valid;
  assign sc.full_scale = full_scale;
  assign sc.bias = bias_sel;
  assign sc.gain = gain_sel;
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_b_i)
    begin
      busy <= 1'b0;
      sc.start <= 1'b0;
    end
    else
    begin
      sc.start <= 1'b0;
      if (sc.done)
      begin
        busy <= 1'b0;
      end
      else if (!busy && enabled && !is_torque && gain_sel != GAIN_DIRECT)
      begin
        sc.start <= 1'b1;
        busy <= 1'b1;
      end
    end
  end

  pdsi_scaler u_scaler (
    .ref_clk_i(ref_clk_i),
    .rst_b_i(rst_b_i),
    .sc(sc)
  );

  // Add compensation only in comp modes; direct mode bypasses scaling
  assign sum = 17'(gain_sel == GAIN_DIRECT ? last_valid : sc.result) + (comp_on ? 17'(analog_comp_i) : 17'd0);

  // Set-point and torque outputs
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_b_i)
    begin
      setpoint_o <= '0;
      setpoint_valid_o <= 1'b0;
      torque_cmd_o <= '0;
      torque_valid_o <= 1'b0;
    end
    else
    begin
      setpoint_valid_o <= enabled && !is_torque;
      torque_valid_o <= enabled && is_torque;
      torque_cmd_o <= is_torque ? masked : 16'h0000;
      if (enabled && !is_torque && (gain_sel == GAIN_DIRECT || sc.done))
      begin
        setpoint_o <= sum[16] ? 16'hFFFF : sum[15:0];
      end
      else if (!enabled || is_torque)
      begin
        setpoint_o <= 16'h0000;
      end
    end
  end

  assign input_unit_increment_o = input_unit_increment;

  // Read-back, one cycle after the read strobe
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_b_i)
    begin
      rdata_o <= '0;
    end
    else if (rd_i)
    begin
      if (addr_i == A_METHOD)
        rdata_o <= {2'b00, input_method_select};
      else if (addr_i == A_TIMING)
        rdata_o <= {12'h000, read_timing_select};
      else if (addr_i == A_BCD_BIAS)
        rdata_o <= bcd_bias_setting;
      else if (addr_i == A_BCD_GAIN)
        rdata_o <= bcd_gain_setting;
      else if (addr_i == A_BIN_BIAS)
        rdata_o <= binary_bias_setting;
      else if (addr_i == A_BIN_GAIN)
        rdata_o <= binary_gain_setting;
      else if (addr_i == A_INCR)
        rdata_o <= {14'h0000, input_unit_increment};
      else if (addr_i == A_WORD)
        rdata_o <= captured;
      else if (addr_i == A_STATUS)
        rdata_o <= {12'h000, busy, digits_ok, is_torque, enabled};
      else
        rdata_o <= 16'h0000;
    end
  end
endmodule
`default_nettype wire

// [inc/pdsi_pkg.sv]
// Package: shared constants and types of the parallel digital set-point input
`default_nettype none
package pdsi_pkg;
  // Input method selector codes
  localparam logic [13:0] SEL_BCD3 = 14'd0;
  localparam logic [13:0] SEL_BIN12 = 14'd1;
  localparam logic [13:0] SEL_BCD3_COMP = 14'd2;
  localparam logic [13:0] SEL_BIN12_COMP = 14'd3;
  localparam logic [13:0] SEL_TRQ12 = 14'd4;
  localparam logic [13:0] SEL_BCD4 = 14'd10;
  localparam logic [13:0] SEL_BIN16 = 14'd11;
  localparam logic [13:0] SEL_BCD4_COMP = 14'd12;
  localparam logic [13:0] SEL_BIN16_COMP = 14'd13;
  localparam logic [13:0] SEL_TRQ16 = 14'd14;
  localparam logic [13:0] SEL_OFF = 14'd9999;
  // Read timing codes
  localparam logic [3:0] RT_CONT = 4'd0;
  localparam logic [3:0] RT_STROBE = 4'd1;
  localparam logic [3:0] RT_FILTER = 4'd10;
  // Gain value meaning direct mode, and defaults (0.01 Hz units)
  localparam logic [15:0] GAIN_DIRECT = 16'd9999;
  localparam logic [15:0] GAIN_DEFAULT = 16'd6000;
  localparam logic [15:0] GAIN_DEFAULT_REGIONAL = 16'd5000;
  localparam logic [15:0] BIAS_DEFAULT = 16'd0;
  localparam logic [15:0] FREQ_LIMIT = 16'd40000;
  // Full-scale decoded values
  localparam logic [15:0] FS_BCD3 = 16'd999;
  localparam logic [15:0] FS_BCD4 = 16'd9999;
  localparam logic [15:0] FS_BIN12 = 16'h0FFF;
  localparam logic [15:0] FS_BIN16 = 16'hFFFF;
  // Filter settle time and cycle count at 10 MHz
  localparam int FILTER_TIME_US = 10;
  localparam int CLK_MHZ = 10;
  localparam int FILTER_CYCLES = FILTER_TIME_US * CLK_MHZ;
  localparam logic [1:0] INCR_DEFAULT = 2'd1;
  // Parameter port addresses
  localparam logic [3:0] A_METHOD = 4'h0;
  localparam logic [3:0] A_TIMING = 4'h1;
  localparam logic [3:0] A_BCD_BIAS = 4'h2;
  localparam logic [3:0] A_BCD_GAIN = 4'h3;
  localparam logic [3:0] A_BIN_BIAS = 4'h4;
  localparam logic [3:0] A_BIN_GAIN = 4'h5;
  localparam logic [3:0] A_INCR = 4'h6;
  localparam logic [3:0] A_WORD = 4'h7;
  localparam logic [3:0] A_STATUS = 4'h8;
  // Scaler states
  typedef enum logic [1:0] {PDSI_IDLE, PDSI_DIV, PDSI_DONE} pdsi_state_e;
endpackage
`default_nettype wire

// [inc/pdsi_scale_if.sv]
// Interface: request and answer between the decoder and the scaler
`timescale 1ns/10ps
`default_nettype none
interface pdsi_scale_if;
  logic start;
  logic [15:0] value;
  logic [15:0] full_scale;
  logic [15:0] bias;
  logic [15:0] gain;
  logic done;
  logic [15:0] result;
  modport req (output start, value, full_scale, bias, gain, input done, result);
  modport srv (input start, value, full_scale, bias, gain, output done, result);
endinterface
`default_nettype wire

// [hdl/pdsi_input_filter.sv]
// Input filter: passes a word on only after it has stood still for a set time
`timescale 1ns/10ps
`default_nettype none
module pdsi_input_filter
  import pdsi_pkg::*;
#(
  parameter int WIDTH = 16,
  parameter int SETTLE = FILTER_CYCLES
)
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  // Raw and settled word
  input wire logic [WIDTH-1:0] raw_i,
  output logic [WIDTH-1:0] settled_o
);
  // Counter sized from the settle time so a long filter never wraps
  localparam int CW = $clog2(SETTLE + 1);
  logic [WIDTH-1:0] last;
  logic [CW-1:0] count;

  // Restart the count on every change so line skew never leaks through
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_b_i)
    begin
      last <= '0;
      count <= '0;
    end
    else if (raw_i != last)
    begin
      last <= raw_i;
      count <= '0;
    end
    else if (count != CW'(SETTLE))
    begin
      count <= count + CW'(1);
    end
  end

  // Settled output updates once the word was stable long enough
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_b_i)
    begin
      settled_o <= '0;
    end
    else if (count == CW'(SETTLE))
    begin
      settled_o <= last;
    end
  end
endmodule
`default_nettype wire

// [hdl/pdsi_scaler.sv]
// Scaler: linear bias/gain interpolation by a serial divider
`timescale 1ns/10ps
`default_nettype none
module pdsi_scaler
  import pdsi_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  // Request from the decoder
  pdsi_scale_if.srv sc
);
  pdsi_state_e state;
  logic [47:0] rem;
  logic [31:0] quot;
  logic [5:0] bitn;
  logic [15:0] base;
  logic neg;
  logic [47:0] trial;

  // Shifted remainder for the trial subtract of the divisor
  assign trial = {rem[46:0], 1'b0};

  // Restoring divide of value*|gain-bias| by full scale, 32 steps
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_b_i)
    begin
      state <= PDSI_IDLE;
      rem <= '0;
      quot <= '0;
      bitn <= '0;
      base <= '0;
      neg <= 1'b0;
      sc.result <= '0;
      sc.done <= 1'b0;
    end
    else
    begin
      sc.done <= 1'b0;
      case (state)
        PDSI_IDLE:
        begin
          if (sc.start)
          begin
            neg <= sc.gain < sc.bias;
            base <= sc.bias;
            rem <= '0;
            quot <= 32'(sc.value) * 32'((sc.gain < sc.bias) ? 16'(sc.bias - sc.gain) : 16'(sc.gain - sc.bias));
            bitn <= 6'd0;
            state <= PDSI_DIV;
          end
        end
        PDSI_DIV:
        begin
          if (({trial[47:1], quot[31]}) >= {32'd0, sc.full_scale})
          begin
            rem <= {trial[47:1], quot[31]} - {32'd0, sc.full_scale};
            quot <= {quot[30:0], 1'b1};
          end
          else
          begin
            rem <= {trial[47:1], quot[31]};
            quot <= {quot[30:0], 1'b0};
          end
          bitn <= bitn + 6'd1;
          if (bitn == 6'd31)
          begin
            state <= PDSI_DONE;
          end
        end
        default:
        begin
          sc.result <= neg ? 16'(base - quot[15:0]) : 16'(base + quot[15:0]);
          sc.done <= 1'b1;
          state <= PDSI_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// [test/pdsi_checker.sv]
// Checker: port-level properties of the set-point input
`timescale 1ns/10ps
`default_nettype none
module pdsi_checker
  import pdsi_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  // Watched ports
  input wire logic [3:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic drive_running_i,
  input wire logic param_clear_i,
  input wire logic setpoint_valid_o,
  input wire logic [15:0] torque_cmd_o,
  input wire logic torque_valid_o,
  input wire logic [1:0] input_unit_increment_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);
  // Method shadow; age saturates so only settled modes are judged
  logic [13:0] meth;
  logic [2:0] age;
  logic settled;
  logic trq;
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_b_i || param_clear_i)
    begin
      meth <= SEL_OFF;
      age <= 3'h0;
    end
    else if (wr_i && addr_i == A_METHOD)
    begin
      meth <= wdata_i[13:0];
      age <= 3'h0;
    end
    else if (age != 3'h7)
      age <= age + 3'h1;
  end
  // Settled-mode flags
  assign settled = (age == 3'h7);
  assign trq = (meth == SEL_TRQ12) || (meth == SEL_TRQ16);
  // Accepted increment write, then an unchanged increment
  sequence incr_write;
    wr_i && addr_i == A_INCR && wdata_i < 16'h0004 && !drive_running_i && !param_clear_i;
  endsequence
  sequence incr_held;
    $stable(input_unit_increment_o);
  endsequence
  chk_off_silent: assert property (settled && meth == SEL_OFF |-> !setpoint_valid_o && !torque_valid_o)
    else $error("output valid while disabled");
  chk_torque_only: assert property (settled && trq |-> torque_valid_o && !setpoint_valid_o)
    else $error("torque mode gives a set-point");
  chk_narrow_torque: assert property (settled && meth == SEL_TRQ12 |-> torque_cmd_o[15:12] == 4'h0)
    else $error("upper lines seen in narrow torque");
  chk_freq_mode: assert property (settled && meth != SEL_OFF && !trq |-> setpoint_valid_o && !torque_valid_o)
    else $error("frequency mode not valid");
  chk_incr_running: assert property (drive_running_i |=> incr_held)
    else $error("increment changed while running");
  chk_incr_clear: assert property (param_clear_i |=> incr_held)
    else $error("increment changed by clear");
  chk_incr_write: assert property (incr_write |=> input_unit_increment_o == $past(wdata_i[1:0]))
    else $error("increment write lost while stopped");
  chk_reset_state: assert property (disable iff (1'b0) !rst_b_i |=> !setpoint_valid_o && input_unit_increment_o == 2'h1)
    else $error("wrong state after reset");
endmodule
bind pdsi_top pdsi_checker i_chk (.ref_clk_i, .rst_b_i, .addr_i, .wdata_i, .wr_i, .drive_running_i,
  .param_clear_i, .setpoint_valid_o, .torque_cmd_o, .torque_valid_o, .input_unit_increment_o);
`default_nettype wire

// [test/pdsi_ctrl_model.sv]
// Partner: controller driving the parallel lines and read strobe
`timescale 1ns/10ps
`default_nettype none
module pdsi_ctrl_model
(
  // Clock
  input wire logic ref_clk_i,
  // Commands from the bench
  input wire logic [15:0] word_i,
  input wire logic strobe_i,
  input wire logic garble_i,
  // Lines toward the block
  output logic [15:0] bits_o,
  output logic strobe_o
);
  // Churn so that unvouched lines never look stable
  logic [15:0] noise = 16'h0000;
  always @(posedge ref_clk_i)
    noise <= noise + 16'h1357;
  // Data only vouched for while the strobe is high
  assign strobe_o = strobe_i;
  assign bits_o = (garble_i && !strobe_i) ? ~word_i ^ noise : word_i;
endmodule
`default_nettype wire

// [test/testbench.sv]
// Testbench: random and corner-case checks of the set-point input
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import pdsi_pkg::*;
  // ----------------
  // Bench and design
  // ----------------
  logic ref_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [15:0] word = 16'h0, comp = 16'h0, wdata = 16'h0, bits, rdata, sp, tq;
  logic stb = 1'b0, garble = 1'b0, run = 1'b0, clr = 1'b0, wr = 1'b0, rd = 1'b0, stb_l, spv, tqv;
  logic [3:0] addr = 4'h0;
  logic [1:0] incr;
  int err_total = 0, num_checks = 0, seed = 32'h09b7;
  localparam logic [13:0] MODES [8] = '{SEL_BCD3, SEL_BIN12, SEL_BCD3_COMP, SEL_BIN12_COMP,
    SEL_BCD4, SEL_BIN16, SEL_BCD4_COMP, SEL_BIN16_COMP};
  localparam logic [15:0] RSTV [7] = '{16'h270F, 16'h0000, 16'h0000, 16'h1770, 16'h0000, 16'h1770, 16'h0001};
  always #50 ref_clk_i = ~ref_clk_i;
  pdsi_ctrl_model i_ctrl (.ref_clk_i(ref_clk_i), .word_i(word), .strobe_i(stb), .garble_i(garble),
    .bits_o(bits), .strobe_o(stb_l));
  // Short filter keeps the skew test brief
  pdsi_top #(.SETTLE(4)) i_dut (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .parallel_input_bits_i(bits),
    .read_strobe_i(stb_l), .analog_comp_i(comp), .drive_running_i(run), .param_clear_i(clr),
    .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .setpoint_o(sp),
    .setpoint_valid_o(spv), .torque_cmd_o(tq), .torque_valid_o(tqv), .input_unit_increment_o(incr));
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask
  task automatic chk(input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e)
    begin
      err_total++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic conclude();
    if (err_total == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // One-cycle strobes on the parameter port
  task automatic wrp(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk_i);
    wr <= 1'b0;
  endtask
  task automatic rdc(input logic [3:0] a, input logic [15:0] e);
    @(posedge ref_clk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk_i);
    rd <= 1'b0;
    #1 chk(e, rdata);
    @(posedge ref_clk_i);
  endtask
  // Wait, then compare the set-point; ends on an edge
  task automatic spc(input int n, input logic [15:0] e);
    cyc(n);
    #1 chk(e, sp);
    @(posedge ref_clk_i);
  endtask
  function automatic bit isbcd(input logic [13:0] m);
    return m == SEL_BCD3 || m == SEL_BCD3_COMP || m == SEL_BCD4 || m == SEL_BCD4_COMP;
  endfunction
  // Decoded value: narrow modes drop the top nibble
  function automatic logic [15:0] dec(input logic [13:0] m, input logic [15:0] w);
    logic [15:0] v;
    v = (m <= SEL_TRQ12) ? {4'h0, w[11:0]} : w;
    if (isbcd(m))
      v = v[15:12] * 16'h03E8 + v[11:8] * 16'h0064 + v[7:4] * 16'h000A + v[3:0];
    return v;
  endfunction
  // Compensation only in the four adding modes, saturating
  function automatic logic [15:0] addc(input logic [13:0] m, input logic [15:0] v, input logic [15:0] c);
    logic [16:0] s;
    s = {1'b0, v};
    if (m == SEL_BCD3_COMP || m == SEL_BIN12_COMP || m == SEL_BCD4_COMP || m == SEL_BIN16_COMP)
      s = s + {1'b0, c};
    return s[16] ? 16'hFFFF : s[15:0];
  endfunction
  function automatic logic [15:0] scl(input logic [15:0] v, f, b, g);
    return b + 16'((32'(v) * 32'(g - b)) / 32'(f));
  endfunction
  function automatic logic [15:0] rbcd();
    logic [15:0] w;
    for (int i = 0; i < 4; i++)
      w[i*4 +: 4] = 4'($unsigned($random(seed)) % 10);
    return w;
  endfunction
  initial
  begin
    logic [15:0] w;
    logic [13:0] m;
    cyc(2);
    rst_b_i <= 1'b1;
    // Reset values, then an unmapped address
    for (int a = 0; a < 7; a++)
      rdc(4'(a), RSTV[a]);
    rdc(4'h9, 16'h0000);
    // Direct decode of every frequency method, strobe toggling
    wrp(4'h3, GAIN_DIRECT);
    wrp(4'h5, GAIN_DIRECT);
    for (int i = 0; i < 16; i++)
    begin
      m = MODES[i % 8];
      w = isbcd(m) ? rbcd() : 16'($random(seed));
      if (m <= SEL_TRQ12)
        w[15:12] = 4'($random(seed));
      comp <= 16'($unsigned($random(seed)) % 2000);
      word <= w;
      stb <= i[0];
      wrp(4'h0, {2'h0, m});
      spc(8, addc(m, dec(m, w), comp));
    end
    // A digit above nine keeps the last good value
    wrp(4'h0, {2'h0, SEL_BCD4});
    word <= 16'h1234;
    spc(8, 16'h04D2);
    word <= 16'h12A4;
    spc(8, 16'h04D2);
    // Torque methods give the raw word only
    for (int i = 0; i < 2; i++)
    begin
      w = 16'($random(seed));
      word <= w;
      wrp(4'h0, i ? {2'h0, SEL_TRQ16} : {2'h0, SEL_TRQ12});
      cyc(8);
      #1 chk(i ? w : {4'h0, w[11:0]}, tq);
      chk(16'h0002, {14'h0, tqv, spv});
      @(posedge ref_clk_i);
    end
    // Gain clamp, then linear scaling between bias and gain
    wrp(4'h5, 16'hAFC8);
    rdc(4'h5, FREQ_LIMIT);
    wrp(4'h4, 16'h01F4);
    wrp(4'h5, GAIN_DEFAULT);
    wrp(4'h0, {2'h0, SEL_BIN16});
    for (int i = 0; i < 4; i++)
    begin
      w = i == 0 ? 16'h0000 : i == 1 ? 16'hFFFF : 16'($random(seed));
      word <= w;
      spc(80, scl(w, FS_BIN16, 16'h01F4, GAIN_DEFAULT));
    end
    wrp(4'h3, 16'h0BB8);
    wrp(4'h2, 16'h0064);
    wrp(4'h0, {2'h0, SEL_BCD3});
    word <= 16'hF999;
    spc(80, 16'h0BB8);
    w = rbcd();
    word <= w;
    spc(80, scl(dec(SEL_BCD3, w), FS_BCD3, 16'h0064, 16'h0BB8));
    // Direct mode: bias neither settable nor applied
    wrp(4'h5, GAIN_DIRECT);
    wrp(4'h4, 16'h02BC);
    rdc(4'h4, 16'h01F4);
    wrp(4'h0, {2'h0, SEL_BIN16});
    word <= 16'h0005;
    spc(8, 16'h0005);
    // Increment: locked while running, kept over a clear
    run <= 1'b1;
    wrp(4'h6, 16'h0003);
    rdc(4'h6, 16'h0001);
    run <= 1'b0;
    wrp(4'h6, 16'h0002);
    @(posedge ref_clk_i);
    clr <= 1'b1;
    @(posedge ref_clk_i);
    clr <= 1'b0;
    rdc(4'h6, 16'h0002);
    rdc(4'h0, 16'h270F);
    // Strobed capture after a reset with the strobe low
    stb <= 1'b0;
    word <= 16'h0000;
    rst_b_i <= 1'b0;
    cyc(2);
    rst_b_i <= 1'b1;
    wrp(4'h1, {12'h0, RT_STROBE});
    garble <= 1'b1;
    wrp(4'h4, 16'h00C8);
    wrp(4'h0, {2'h0, SEL_BIN16});
    spc(80, 16'h00C8);
    word <= 16'hFFFF;
    stb <= 1'b1;
    cyc(4);
    stb <= 1'b0;
    spc(80, GAIN_DEFAULT);
    rdc(4'h7, 16'hFFFF);
    // Filter: a short skew word never reaches the output
    wrp(4'h5, GAIN_DIRECT);
    wrp(4'h1, {12'h0, RT_FILTER});
    garble <= 1'b0;
    word <= 16'h0100;
    spc(20, 16'h0100);
    word <= 16'h01FF;
    cyc(2);
    word <= 16'h0F00;
    for (int i = 0; i < 12; i++)
    begin
      cyc(1);
      #1 chk(16'h0001, {15'h0, sp === 16'h0100 || sp === 16'h0F00});
    end
    spc(4, 16'h0F00);
    rdc(4'h8, 16'h0001);
    conclude();
  end
  // Watchdog well beyond the expected run length
  initial
  begin
    cyc(20000);
    err_total++;
    conclude();
  end
endmodule
`default_nettype wire
